// >>> verilog/dms_pkg.sv
package dms_pkg;
  // Register offsets
  localparam logic [4:0] OFS_RX_BUFFER = 5'h00;
  localparam logic [4:0] OFS_TX_BUFFER = 5'h04;
  localparam logic [4:0] OFS_RATE = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;
  localparam logic [4:0] OFS_COMMAND = 5'h10;
  localparam logic [4:0] OFS_MODEM_CMD = 5'h18;
  // Status bits
  localparam int ST_OVERRUN = 10;
  localparam int ST_FRAMING = 9;
  localparam int ST_PARITY = 8;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_RX_FULL = 4;
  localparam int ST_ERR_REQ = 3;
  localparam int ST_RXF_REQ = 2;
  localparam int ST_TXE_REQ = 1;
  localparam int ST_END_REQ = 0;
  // Command bits
  localparam int CM_RX_EN = 15;
  localparam int CM_TX_EN = 14;
  localparam int CM_GIE = 12;
  localparam int CM_ERR_IE = 11;
  localparam int CM_RXF_IE = 10;
  localparam int CM_TXE_IE = 9;
  localparam int CM_END_IE = 8;
  localparam int CM_SYNC = 6;
  localparam int CM_FLAG_MODE = 5;
  localparam int CM_FLAG_VAL = 4;
  localparam int CM_SEVEN = 3;
  localparam int CM_PAR_HI = 2;
  localparam int CM_PAR_LO = 1;
  localparam int CM_TWO_STOP = 0;
  localparam int MC_AUTO = 8;
  localparam int RATE_PRE_HI = 10;
  localparam int RATE_PRE_LO = 8;
  // Reset values
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [10:0] RATE_RST = 11'h000;
  localparam logic TX_EMPTY_RST = 1'b1;
  // Tick counts inside one bit (x8 sync, x16 start-stop)
  localparam logic [3:0] LAST_TK_SYNC = 4'h7;
  localparam logic [3:0] LAST_TK_ASYNC = 4'hf;
  localparam logic [3:0] RISE_TK = 4'h3;
  localparam logic [3:0] START_MID_TK = 4'h7;
  localparam logic [1:0] PAR_NONE = 2'h0;

  typedef struct packed {
    logic seven;
    logic [1:0] par;
    logic fbm;
    logic fbv;
    logic two;
  } dms_cfg_s;

  typedef struct packed {
    logic [11:0] bits;
    logic [3:0] len;
  } dms_frame_s;

  typedef struct packed {
    logic [7:0] data;
    logic par_err;
    logic flag_bad;
    logic frm_err;
  } dms_rx_s;

  function automatic logic [5:0] prescale_n(input logic [2:0] code);
    unique case (code)
      3'h0: prescale_n = 6'd1;
      3'h1: prescale_n = 6'd2;
      3'h2: prescale_n = 6'd4;
      3'h3: prescale_n = 6'd8;
      3'h4: prescale_n = 6'd16;
      3'h5: prescale_n = 6'd32;
      default: prescale_n = 6'd62;
    endcase
  endfunction : prescale_n

  function automatic logic has_extra(input dms_cfg_s c);
    has_extra = c.fbm ? (c.par == PAR_NONE) : c.par[1];
  endfunction : has_extra

  // Index of the stop bit counted from the first data bit
  function automatic logic [3:0] stop_idx(input dms_cfg_s c);
    stop_idx = (c.seven ? 4'd7 : 4'd8) + {3'h0, has_extra(c)};
  endfunction : stop_idx

  function automatic logic extra_bit(input logic [7:0] dm, input dms_cfg_s c);
    extra_bit = c.fbm ? c.fbv : (^dm ^ c.par[0]);
  endfunction : extra_bit

  function automatic dms_frame_s build_frame(input logic [7:0] d, input dms_cfg_s c,
                                             input logic sync);
    dms_frame_s f;
    logic [11:0] b;
    logic [7:0] dm;
    logic [3:0] i;
    dm = c.seven ? {1'b0, d[6:0]} : d;
    b = 12'hfff;
    i = stop_idx(c);
    if (sync) begin
      b[7:0] = d;
      f.len = 4'h8;
    end else begin
      b[0] = 1'b0;
      b[8:1] = dm;
      if (c.seven) b[8] = 1'b1;
      if (has_extra(c)) b[i] = extra_bit(dm, c);
      f.len = i + 4'h1 + (c.two ? 4'h2 : 4'h1);
    end
    f.bits = b;
    return f;
  endfunction : build_frame

  function automatic dms_rx_s rx_eval(input logic [8:0] fb, input logic stop,
                                      input dms_cfg_s c);
    dms_rx_s r;
    logic xb;
    r.data = c.seven ? {1'b0, fb[6:0]} : fb[7:0];
    xb = c.seven ? fb[7] : fb[8];
    r.par_err = !c.fbm && c.par[1] && (xb != (^r.data ^ c.par[0]));
    r.flag_bad = c.fbm && (c.par == PAR_NONE) && (xb != c.fbv);
    r.frm_err = !stop;
    return r;
  endfunction : rx_eval
endpackage : dms_pkg

// >>> verilog/dms_link_if.sv
`timescale 1ns/1ns
interface dms_link_if;
  logic txd;
  logic rxd;
  logic sclk;
  logic cts;
  modport dev (output txd, output sclk, input rxd, input cts);
  modport peer (input txd, input sclk, output rxd, output cts);
endinterface : dms_link_if

// >>> verilog/dms_port.sv
// Notes on behaviour
// RULE_01: Sync mode bit shifts bytes on own clock
// RULE_02: Sync words are eight bits, no extra bit
// RULE_03: Bit rate from prescaler and adjust divider
// RULE_04: Transmit needs enable, and CTS if auto
// RULE_05: Sync data LSB first, changes on falling
// RULE_06: Empty rise raises gated empty request
// RULE_07: Software loads buffer then clears empty
// RULE_08: Sync transmit end stops clock, requests end
// RULE_09: Sync receive runs clock when enabled
// RULE_10: Sync receive samples rising, stores byte
// RULE_11: Receive full raises gated full request
// RULE_12: Dropping receive enable stores partial word
// RULE_13: Full buffer on arrival sets overrun
// RULE_14: Error flags raise gated error request
// RULE_15: Start bit, then seven or eight data
// RULE_16: Parity or flag bit after data
// RULE_17: One or two stop bits sent
// RULE_18: Last stop with empty buffer ends transmit
// RULE_19: Falling edge starts receive, start bit checked
// RULE_20: Receiver takes one stop bit only
// RULE_21: Wrong flag bit blocks buffer update
// RULE_22: Stop zero framing, mismatch parity error
// RULE_23: Prescaler code maps to divide factor
// RULE_24: Receive samples bit centre at x16
`timescale 1ns/1ns
module dms_port (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset
  input wire logic [4:0] addr, // Register byte address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after rd
  output logic irq, // Any request pending
  dms_link_if.dev link // Serial link
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} dms_rx_e;

  logic [15:0] cmd_r;
  logic [10:0] rate_r;
  logic auto_enable_r;
  logic [7:0] tx_buffer_r, rx_buffer_r;
  logic tx_buffer_empty_r, rx_buffer_full_r;
  logic overrun_flag_r, framing_error_flag_r, parity_error_flag_r;
  logic tx_empty_request_r, tx_end_request_r, rx_full_request_r, rx_error_request_r;
  logic [15:0] rdata_r;
  logic [5:0] pre_cnt_r;
  logic [7:0] adj_cnt_r;
  logic rxd_m_r, rxd_s_r, rxd_d_r, cts_m_r, cts_s_r;
  logic run_r, tx_has_r, rx_word_r, txd_r, sclk_r;
  logic [3:0] tk_r, bit_r, len_r;
  logic [10:0] tsh_r;
  logic [7:0] rsh_r;
  dms_rx_e ars_r;
  logic [3:0] atk_r, abit_r;
  logic [8:0] afr_r;

  dms_pkg::dms_cfg_s cfg;
  dms_pkg::dms_frame_s frame;
  dms_pkg::dms_rx_s arx;
  wire sync_mode_select = cmd_r[dms_pkg::CM_SYNC];
  wire global_irq_enable = cmd_r[dms_pkg::CM_GIE];
  assign cfg = '{seven: cmd_r[dms_pkg::CM_SEVEN],
                 par: cmd_r[dms_pkg::CM_PAR_HI:dms_pkg::CM_PAR_LO],
                 fbm: cmd_r[dms_pkg::CM_FLAG_MODE], fbv: cmd_r[dms_pkg::CM_FLAG_VAL],
                 two: cmd_r[dms_pkg::CM_TWO_STOP]};
  wire ie_txe = global_irq_enable & cmd_r[dms_pkg::CM_TXE_IE];
  wire ie_end = global_irq_enable & cmd_r[dms_pkg::CM_END_IE];
  wire ie_rxf = global_irq_enable & cmd_r[dms_pkg::CM_RXF_IE];
  wire ie_err = global_irq_enable & cmd_r[dms_pkg::CM_ERR_IE];

  // Register strobes
  wire wr_cmd = wr && addr == dms_pkg::OFS_COMMAND;
  wire wr_stat = wr && addr == dms_pkg::OFS_STATUS;
  wire clr_ovr = wr_stat & ~wdata[dms_pkg::ST_OVERRUN];
  wire clr_frm = wr_stat & ~wdata[dms_pkg::ST_FRAMING];
  wire clr_par = wr_stat & ~wdata[dms_pkg::ST_PARITY];
  // RULE_07 software marks buffer valid
  wire clr_txe = wr_stat & ~wdata[dms_pkg::ST_TX_EMPTY];
  wire clr_rxf = wr_stat & ~wdata[dms_pkg::ST_RX_FULL];
  wire clr_end = wr_stat & ~wdata[dms_pkg::ST_END_REQ];

  // RULE_03 divider n x (256 - P) per tick
  // RULE_23 prescaler code decode
  wire [5:0] pre_n = dms_pkg::prescale_n(rate_r[dms_pkg::RATE_PRE_HI:dms_pkg::RATE_PRE_LO]);
  wire pre_done = pre_cnt_r == pre_n - 6'd1;
  wire tick = pre_done && adj_cnt_r == 8'hff;

  // RULE_04 start gate with auto enable
  wire tx_go = cmd_r[dms_pkg::CM_TX_EN] & (~auto_enable_r | cts_s_r);
  wire tx_ready = tx_go & ~tx_buffer_empty_r;
  // RULE_09 receive needs auto enable off
  wire rx_on = cmd_r[dms_pkg::CM_RX_EN] & ~auto_enable_r;
  wire rx_stop = wr_cmd & ~wdata[dms_pkg::CM_RX_EN] & cmd_r[dms_pkg::CM_RX_EN];
  wire cont = tx_ready | (sync_mode_select & rx_on);
  wire [3:0] last_tk = sync_mode_select ? dms_pkg::LAST_TK_SYNC : dms_pkg::LAST_TK_ASYNC;
  wire bit_end = run_r & tick & (tk_r == last_tk);
  wire frame_end = bit_end & (bit_r == len_r - 4'h1);
  // Idle start waits for a tick, else the first bit comes out short
  wire load = ((~run_r & tick) | frame_end) & cont;
  // RULE_10 sampling at rising edge
  wire sync_rise = run_r & tick & sync_mode_select & (tk_r == dms_pkg::RISE_TK);
  // RULE_02 sync frame ignores format fields
  assign frame = dms_pkg::build_frame(tx_ready ? tx_buffer_r : 8'hff, cfg, sync_mode_select);
  // RULE_18 end only with buffer empty
  wire end_ev = frame_end & tx_has_r & tx_buffer_empty_r;

  // Start-stop receiver
  wire rx_fall = rxd_d_r & ~rxd_s_r;
  wire [3:0] rx_stop_idx = dms_pkg::stop_idx(cfg);
  // RULE_20 single stop bit sampled
  wire a_done = ars_r == RX_BITS && tick && atk_r == dms_pkg::LAST_TK_ASYNC
                && abit_r == rx_stop_idx;
  assign arx = dms_pkg::rx_eval(afr_r, rxd_s_r, cfg);

  // Delivery into the receive buffer
  // RULE_12 partial word on receive disable
  wire partial = rx_stop & run_r & rx_word_r & ~frame_end;
  wire deliv = a_done | (frame_end & rx_word_r) | partial;
  // RULE_21 flag mismatch blocks store
  wire blocked = a_done & arx.flag_bad;
  wire store = deliv & ~blocked & ~rx_buffer_full_r;
  // RULE_13 overrun keeps buffer
  wire ovr_ev = deliv & ~blocked & rx_buffer_full_r;
  wire [7:0] deliv_d = a_done ? arx.data : rsh_r;

  wire [15:0] status = {5'h00, overrun_flag_r, framing_error_flag_r, parity_error_flag_r,
                        2'h0, tx_buffer_empty_r, rx_buffer_full_r, rx_error_request_r,
                        rx_full_request_r, tx_empty_request_r, tx_end_request_r};
  wire [15:0] rd_mux =
    addr == dms_pkg::OFS_RX_BUFFER ? {8'h00, rx_buffer_r} :
    addr == dms_pkg::OFS_TX_BUFFER ? {8'h00, tx_buffer_r} :
    addr == dms_pkg::OFS_RATE ? {5'h00, rate_r} :
    addr == dms_pkg::OFS_STATUS ? status :
    addr == dms_pkg::OFS_COMMAND ? (cmd_r & 16'hdf7f) :
    addr == dms_pkg::OFS_MODEM_CMD ? {7'h00, auto_enable_r, 8'h00} : 16'h0000;

  assign rdata = rdata_r;
  assign irq = tx_empty_request_r | tx_end_request_r | rx_full_request_r | rx_error_request_r;
  assign link.txd = txd_r;
  assign link.sclk = sclk_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= dms_pkg::CMD_RST;
      rate_r <= dms_pkg::RATE_RST;
      auto_enable_r <= 1'b0;
      tx_buffer_r <= 8'h00;
      rdata_r <= 16'h0000;
    end else begin
      if (wr_cmd) cmd_r <= wdata;
      if (wr && addr == dms_pkg::OFS_RATE) rate_r <= wdata[10:0];
      if (wr && addr == dms_pkg::OFS_MODEM_CMD) auto_enable_r <= wdata[dms_pkg::MC_AUTO];
      if (wr && addr == dms_pkg::OFS_TX_BUFFER) tx_buffer_r <= wdata[7:0];
      rdata_r <= rd ? rd_mux : 16'h0000;
    end
  end

  // Flags: hardware set wins over software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buffer_empty_r <= dms_pkg::TX_EMPTY_RST;
      rx_buffer_full_r <= 1'b0;
      overrun_flag_r <= 1'b0;
      framing_error_flag_r <= 1'b0;
      parity_error_flag_r <= 1'b0;
      rx_buffer_r <= 8'h00;
    end else begin
      tx_buffer_empty_r <= (load & tx_ready) | (tx_buffer_empty_r & ~clr_txe);
      // RULE_11 buffer full on store
      rx_buffer_full_r <= store | (rx_buffer_full_r & ~clr_rxf);
      if (store) rx_buffer_r <= deliv_d;
      overrun_flag_r <= ovr_ev | (overrun_flag_r & ~clr_ovr);
      // RULE_22 framing and parity checks
      framing_error_flag_r <= (a_done & arx.frm_err) | (framing_error_flag_r & ~clr_frm);
      parity_error_flag_r <= (a_done & arx.par_err) | (parity_error_flag_r & ~clr_par);
    end
  end

  // Requests clear when their enable or the global enable is off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty_request_r <= 1'b0;
      tx_end_request_r <= 1'b0;
      rx_full_request_r <= 1'b0;
      rx_error_request_r <= 1'b0;
    end else begin
      // RULE_06 empty rise request
      tx_empty_request_r <= ie_txe & ((load & tx_ready) | (tx_empty_request_r & ~clr_txe));
      // RULE_08 end request, sync or start-stop
      tx_end_request_r <= ie_end & (end_ev | (tx_end_request_r & ~clr_end));
      rx_full_request_r <= ie_rxf & (store | (rx_full_request_r & ~clr_rxf));
      // RULE_14 error request level
      rx_error_request_r <= ie_err & (overrun_flag_r | framing_error_flag_r | parity_error_flag_r);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_r <= 6'h00;
      adj_cnt_r <= 8'h00;
      {rxd_m_r, rxd_s_r, rxd_d_r, cts_m_r, cts_s_r} <= 5'h1f;
    end else begin
      pre_cnt_r <= pre_done ? 6'h00 : pre_cnt_r + 6'h01;
      if (pre_done) adj_cnt_r <= (adj_cnt_r == 8'hff) ? rate_r[7:0] : adj_cnt_r + 8'h01;
      {rxd_m_r, rxd_s_r, rxd_d_r} <= {link.rxd, rxd_m_r, rxd_s_r};
      {cts_m_r, cts_s_r} <= {link.cts, cts_m_r};
    end
  end

  // Frame engine: transmit in both modes, sync receive clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
      tx_has_r <= 1'b0;
      rx_word_r <= 1'b0;
      txd_r <= 1'b1;
      sclk_r <= 1'b1;
      tk_r <= 4'h0;
      bit_r <= 4'h0;
      len_r <= 4'h0;
      tsh_r <= 11'h7ff;
      rsh_r <= 8'h00;
    end else if (load) begin
      // RULE_01 sync word with own clock
      // RULE_15 start bit first, LSB first
      // RULE_16 extra bit from frame builder
      // RULE_17 stop count in frame length
      run_r <= 1'b1;
      tx_has_r <= tx_ready;
      rx_word_r <= sync_mode_select & rx_on;
      txd_r <= frame.bits[0];
      tsh_r <= frame.bits[11:1];
      len_r <= frame.len;
      sclk_r <= ~sync_mode_select;
      tk_r <= 4'h0;
      bit_r <= 4'h0;
      rsh_r <= 8'h00;
    end else if (frame_end) begin
      run_r <= 1'b0;
      tx_has_r <= 1'b0;
      rx_word_r <= 1'b0;
      txd_r <= 1'b1;
      sclk_r <= 1'b1;
      tk_r <= 4'h0;
    end else begin
      if (partial) rx_word_r <= 1'b0;
      if (bit_end) begin
        // RULE_05 data changes with falling clock
        tk_r <= 4'h0;
        bit_r <= bit_r + 4'h1;
        txd_r <= tsh_r[0];
        tsh_r <= {1'b1, tsh_r[10:1]};
        if (sync_mode_select) sclk_r <= 1'b0;
      end else if (run_r && tick) begin
        tk_r <= tk_r + 4'h1;
        if (sync_rise) sclk_r <= 1'b1;
      end
      if (sync_rise && rx_word_r) rsh_r[bit_r[2:0]] <= rxd_s_r;
    end
  end

  // Start-stop receiver
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ars_r <= RX_IDLE;
      atk_r <= 4'h0;
      abit_r <= 4'h0;
      afr_r <= 9'h000;
    end else if (!rx_on || sync_mode_select) begin
      ars_r <= RX_IDLE;
    end else begin
      unique case (ars_r)
        RX_IDLE: if (rx_fall) begin
          ars_r <= RX_START;
          atk_r <= 4'h0;
        end
        RX_START: if (tick) begin
          // RULE_24 centre of start bit
          if (atk_r == dms_pkg::START_MID_TK) begin
            // RULE_19 high start bit abandoned
            ars_r <= rxd_s_r ? RX_IDLE : RX_BITS;
            atk_r <= 4'h0;
            abit_r <= 4'h0;
          end else atk_r <= atk_r + 4'h1;
        end
        RX_BITS: if (tick) begin
          if (atk_r == dms_pkg::LAST_TK_ASYNC) begin
            atk_r <= 4'h0;
            abit_r <= abit_r + 4'h1;
            if (a_done) ars_r <= RX_IDLE;
            else afr_r[abit_r] <= rxd_s_r;
          end else atk_r <= atk_r + 4'h1;
        end
      endcase
    end
  end
endmodule : dms_port

// >>> verilog/dms_peer.sv
`timescale 1ns/1ns
module dms_peer #(
  parameter int CW = 16 // Width of bit period count
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset
  input wire logic sync_mode_select, // 1: clocked words
  input wire logic seven_bit_length, // 7 data bits
  input wire logic [1:0] parity_field, // 00 none, 10 even, 11 odd
  input wire logic flag_bit_mode, // Flag bit instead of parity
  input wire logic flag_bit_value, // Flag bit level
  input wire logic two_stop_select, // Two stop bits sent
  input wire logic [CW-1:0] bit_cycles, // Clocks per start-stop bit
  input wire logic cts_level, // Level driven on CTS
  input wire logic send_valid, // Word offered
  input wire logic [7:0] send_data, // Word to send
  output logic send_ready, // Word taken this cycle
  output logic recv_valid, // Word received, one pulse
  output logic [7:0] recv_data, // Received word
  output logic recv_error, // Frame, parity or flag fault
  dms_link_if.peer link // Serial link
);
  typedef enum logic [1:0] {PR_IDLE, PR_START, PR_BITS} dms_prx_e;

  logic txd_m_r, txd_s_r, txd_d_r, clk_m_r, clk_s_r, clk_d_r;
  logic rxd_r, cts_r, recv_valid_r, recv_error_r;
  logic [7:0] recv_data_r, ssh_r, rsh_r;
  logic [2:0] sidx_r;
  logic tx_busy_r;
  logic [11:0] tsh_r;
  logic [3:0] tbit_r, tlen_r, rbit_r;
  logic [CW-1:0] tcnt_r, rcnt_r;
  dms_prx_e prx_r;
  logic [8:0] rfr_r;

  dms_pkg::dms_cfg_s cfg;
  dms_pkg::dms_frame_s frame;
  dms_pkg::dms_rx_s rx;
  assign cfg = '{seven: seven_bit_length, par: parity_field, fbm: flag_bit_mode,
                 fbv: flag_bit_value, two: two_stop_select};
  assign frame = dms_pkg::build_frame(send_data, cfg, 1'b0);
  assign rx = dms_pkg::rx_eval(rfr_r, txd_s_r, cfg);

  wire s_rise = clk_s_r & ~clk_d_r;
  wire s_fall = ~clk_s_r & clk_d_r;
  wire word_start = s_fall && sidx_r == 3'h0;
  assign send_ready = sync_mode_select ? word_start : ~tx_busy_r;
  wire take = send_valid & send_ready;
  wire tbit_end = tx_busy_r && tcnt_r == bit_cycles - {{(CW-1){1'b0}}, 1'b1};
  wire rbit_end = rcnt_r == bit_cycles - {{(CW-1){1'b0}}, 1'b1};
  wire rmid = rcnt_r == (bit_cycles >> 1);
  wire a_done = prx_r == PR_BITS && rbit_end && rbit_r == dms_pkg::stop_idx(cfg);

  assign link.rxd = rxd_r;
  assign link.cts = cts_r;
  assign recv_valid = recv_valid_r;
  assign recv_data = recv_data_r;
  assign recv_error = recv_error_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {txd_m_r, txd_s_r, txd_d_r, clk_m_r, clk_s_r, clk_d_r} <= 6'h3f;
      cts_r <= 1'b0;
    end else begin
      {txd_m_r, txd_s_r, txd_d_r} <= {link.txd, txd_m_r, txd_s_r};
      {clk_m_r, clk_s_r, clk_d_r} <= {link.sclk, clk_m_r, clk_s_r};
      cts_r <= cts_level;
    end
  end

  // Sender: sync words on falling edges, or start-stop frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_r <= 1'b1;
      ssh_r <= 8'hff;
      tx_busy_r <= 1'b0;
      tsh_r <= 12'hfff;
      tbit_r <= 4'h0;
      tlen_r <= 4'h0;
      tcnt_r <= '0;
    end else if (sync_mode_select) begin
      tx_busy_r <= 1'b0;
      if (word_start) begin
        ssh_r <= take ? send_data : 8'hff;
        rxd_r <= take ? send_data[0] : 1'b1;
      end else if (s_fall) rxd_r <= ssh_r[sidx_r];
    end else if (take) begin
      tx_busy_r <= 1'b1;
      tsh_r <= frame.bits;
      rxd_r <= frame.bits[0];
      tlen_r <= frame.len;
      tbit_r <= 4'h0;
      tcnt_r <= '0;
    end else if (tbit_end) begin
      tcnt_r <= '0;
      tbit_r <= tbit_r + 4'h1;
      tx_busy_r <= tbit_r != tlen_r - 4'h1;
      rxd_r <= (tbit_r == tlen_r - 4'h1) ? 1'b1 : tsh_r[tbit_r + 4'h1];
    end else if (tx_busy_r) tcnt_r <= tcnt_r + {{(CW-1){1'b0}}, 1'b1};
  end

  // Receiver: sync sampling on rising edges, or mid-bit sampling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sidx_r <= 3'h0;
      rsh_r <= 8'h00;
      prx_r <= PR_IDLE;
      rbit_r <= 4'h0;
      rcnt_r <= '0;
      rfr_r <= 9'h000;
      recv_valid_r <= 1'b0;
      recv_data_r <= 8'h00;
      recv_error_r <= 1'b0;
    end else begin
      recv_valid_r <= 1'b0;
      if (sync_mode_select) begin
        prx_r <= PR_IDLE;
        if (s_rise) begin
          sidx_r <= sidx_r + 3'h1;
          rsh_r[sidx_r] <= txd_s_r;
          if (sidx_r == 3'h7) begin
            recv_valid_r <= 1'b1;
            recv_data_r <= {txd_s_r, rsh_r[6:0]};
            recv_error_r <= 1'b0;
          end
        end
      end else begin
        sidx_r <= 3'h0;
        rcnt_r <= rcnt_r + {{(CW-1){1'b0}}, 1'b1};
        unique case (prx_r)
          PR_IDLE: if (txd_d_r && !txd_s_r) begin
            prx_r <= PR_START;
            rcnt_r <= '0;
          end
          PR_START: if (rmid) begin
            prx_r <= txd_s_r ? PR_IDLE : PR_BITS;
            rcnt_r <= '0;
            rbit_r <= 4'h0;
          end
          PR_BITS: if (rbit_end) begin
            rcnt_r <= '0;
            rbit_r <= rbit_r + 4'h1;
            if (a_done) begin
              prx_r <= PR_IDLE;
              recv_valid_r <= 1'b1;
              recv_data_r <= rx.data;
              recv_error_r <= rx.par_err | rx.flag_bad | rx.frm_err;
            end else rfr_r[rbit_r] <= txd_s_r;
          end
        endcase
      end
    end
  end
endmodule : dms_peer

// >>> verif/dms_asserts.sv
`timescale 1ns/1ns
module dms_asserts (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic txd, // Device data out
  input wire logic rxd, // Peer data out
  input wire logic sclk, // Shift clock
  input wire logic cts // Peer CTS
);
  logic [4:0] tlow;
  logic [4:0] rlow;
  // Low run lengths, checked modulo one bit of 32 clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tlow <= 5'h00;
      rlow <= 5'h00;
    end else begin
      tlow <= txd ? 5'h00 : tlow + 5'h01;
      rlow <= rxd ? 5'h00 : rlow + 5'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_tx_fall; $changed(txd) && !sclk |-> $fell(sclk); endproperty
  a_tx_fall: assert property (p_tx_fall) else $error("txd moved off sclk fall");
  property p_sclk_low; $fell(sclk) |=> !sclk [*7] ##1 sclk; endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("sclk low width");
  property p_sclk_high; $rose(sclk) |-> sclk [*8]; endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("sclk high width");
  property p_rx_rise; $rose(sclk) |-> $stable(rxd); endproperty
  a_rx_rise: assert property (p_rx_rise) else $error("rxd moved at sclk rise");
  property p_rx_fall; $changed(rxd) && !sclk |-> !$past(sclk, 2); endproperty
  a_rx_fall: assert property (p_rx_fall) else $error("rxd moved early");
  property p_tx_run; $rose(txd) && sclk && $past(sclk, 12) |-> tlow == 5'h00; endproperty
  a_tx_run: assert property (p_tx_run) else $error("txd bit length");
  property p_rx_run; $rose(rxd) && sclk && $past(sclk, 12) |-> rlow == 5'h00; endproperty
  a_rx_run: assert property (p_rx_run) else $error("rxd bit length");
  property p_tx_start; $fell(txd) && sclk |=> !txd [*8]; endproperty
  a_tx_start: assert property (p_tx_start) else $error("txd start short");
  c_sync: cover property ($fell(sclk));
  c_tx: cover property ($fell(txd) && sclk);
  c_rx: cover property ($fell(rxd) && sclk);
  c_cts: cover property ($rose(cts));
endmodule : dms_asserts

// >>> verif/dms_port_bench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module dms_port_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sm = 1'b0;
  logic sv = 1'b0;
  logic cts = 1'b1;
  logic [1:0] par = 2'h2;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic [7:0] sd = 8'h00;
  logic [15:0] rdata;
  logic [15:0] v;
  logic irq;
  logic srdy;
  logic pv;
  logic perr;
  logic [7:0] pd;
  int n_mismatch = 0;
  int checks = 0;
  dms_link_if lnk ();
  dms_port i_dms_port (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .link(lnk.dev));
  dms_peer i_dms_peer (.clk(clk), .rst_n(rst_n), .sync_mode_select(sm),
    .seven_bit_length(1'b0), .parity_field(par), .flag_bit_mode(1'b0),
    .flag_bit_value(1'b0), .two_stop_select(1'b0), .bit_cycles(16'h0020),
    .cts_level(cts), .send_valid(sv), .send_data(sd), .send_ready(srdy),
    .recv_valid(pv), .recv_data(pd), .recv_error(perr), .link(lnk.peer));
  dms_asserts i_dms_asserts (.clk(clk), .rst_n(rst_n), .txd(lnk.txd), .rxd(lnk.rxd),
    .sclk(lnk.sclk), .cts(lnk.cts));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rreg
  task automatic send_word(input logic [7:0] d);
    sd <= d;
    sv <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 3000 && srdy !== 1'b1; i++) @(posedge clk);
    sv <= 1'b0;
  endtask : send_word
  task automatic wait_pv();
    for (int i = 0; i < 3000 && pv !== 1'b1; i++) @(posedge clk);
  endtask : wait_pv
  task automatic poll_bit(input int b);
    for (int i = 0; i < 1000 && v[b] !== 1'b1; i++) rreg(dms_pkg::OFS_STATUS, v);
  endtask : poll_bit
  task automatic t_reset();
    rreg(dms_pkg::OFS_STATUS, v);
    `CHK("status", 16'h0020, v)
    rreg(5'h14, v);
    `CHK("unmapped", 16'h0000, v)
  endtask : t_reset
  task automatic t_async();
    wreg(dms_pkg::OFS_RATE, 16'h00fe);
    wreg(dms_pkg::OFS_COMMAND, 16'hd504);
    wreg(dms_pkg::OFS_TX_BUFFER, 16'h00a5);
    wreg(dms_pkg::OFS_STATUS, 16'h0000);
    wait_pv();
    `CHK("peer data", 8'ha5, pd)
    `CHK("peer error", 1'b0, perr)
    send_word(8'h3c);
    poll_bit(dms_pkg::ST_RX_FULL);
    `CHK("status", 16'h0035, v)
    `CHK("irq", 1'b1, irq)
    rreg(dms_pkg::OFS_RX_BUFFER, v);
    `CHK("rx buffer", 16'h003c, v)
    wreg(dms_pkg::OFS_STATUS, 16'h0020);
    rreg(dms_pkg::OFS_STATUS, v);
    `CHK("status", 16'h0020, v)
    `CHK("irq", 1'b0, irq)
    // Device set to odd parity, peer still sends even
    wreg(dms_pkg::OFS_COMMAND, 16'hd506);
    send_word(8'h01);
    poll_bit(dms_pkg::ST_RX_FULL);
    `CHK("parity err", 1'b1, v[dms_pkg::ST_PARITY])
    rreg(dms_pkg::OFS_RX_BUFFER, v);
    `CHK("rx buffer", 16'h0001, v)
  endtask : t_async
  task automatic t_sync();
    sm <= 1'b1;
    par <= 2'h0;
    wreg(dms_pkg::OFS_COMMAND, 16'h0040);
    wreg(dms_pkg::OFS_TX_BUFFER, 16'h0096);
    wreg(dms_pkg::OFS_STATUS, 16'h0000);
    wreg(dms_pkg::OFS_COMMAND, 16'hd840);
    send_word(8'h5a);
    wait_pv();
    `CHK("peer data", 8'h96, pd)
    poll_bit(dms_pkg::ST_OVERRUN);
    `CHK("overrun", 1'b1, v[dms_pkg::ST_OVERRUN])
    rreg(dms_pkg::OFS_RX_BUFFER, v);
    `CHK("rx buffer", 16'h005a, v)
    `CHK("irq", 1'b1, irq)
  endtask : t_sync
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_async();
    t_sync();
    end_of_test();
  end
  // Whole run is under two thousand cycles
  initial begin
    #500000;
    n_mismatch++;
    end_of_test();
  end
endmodule : dms_port_bench
